// [bera_analyzer.sv]
// Receive bit error analyzer: counters, pattern capture, sticky status, host port
`timescale 1ns/1ns
// Function
// - 32-bit received-bit counter advances per receive clock while count-disable low.
// - Bit counter holds while pattern sync is lost.
// - Bit counter wrap sets the bit-count overflow flag.
// - Count-latch rising edge copies bit count to readable registers, zeroes it.
// - 32-bit counter of received bits in error against expected pattern.
// - Error counter holds while pattern sync is lost.
// - Error counter wrap sets the error-count overflow flag.
// - Same latch edge copies error count to readable registers, zeroes it.
// - Capture out of sync stores the last 32 received bits.
// - Capture in sync stores the locked pattern in any rotation.
// - Captured pattern in sync is the reference, free of received errors.
// - All status flags except real-time sync stay set until read.
// - Error-seen and overflow flags clear on read, set again only anew.
// - Sync-lost, all-zeros, all-ones flags clear on read only once condition gone.
// - Interrupt asserts for any set status flag whose mask bit is enabled.
// - Pattern-select bit: 1 pseudorandom, 0 repetitive pattern detection.
// - Control bit 6 selects QRSS with tap 10 and length 13 hex.
// - Length 1F with tap 10 gives the documented non-maximal repeat period.
// - Error insertion bit 5 is transmit inversion, bit 4 receive inversion.
// - Count-latch bit ORed with pin; must fall before another latch.
// - Capture bit ORed with pin; rising edge captures, must fall first.
// - Sync sets on lock, clears at 6 errors in 64 bits if auto resync.
module bera_analyzer (
  input wire logic mclk_i, // System clock, 250 MHz
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic rx_clk_i, // Receive bit clock pin
  input wire logic rx_data_i, // Receive serial data pin
  input wire logic rx_count_disable_i, // High holds the counters
  input wire logic count_latch_i, // Count latch pin, rising edge
  input wire logic rx_capture_i, // Pattern capture pin, rising edge
  input wire logic cs_n_i, // Chip select, active low
  input wire logic rd_n_i, // Read strobe, active low
  input wire logic wr_n_i, // Write strobe, active low
  input wire logic [4:0] addr_i, // Register address
  input wire logic [7:0] data_i, // Write data from host
  output logic [7:0] data_o, // Read data to host
  output logic data_oe_o, // High while driving read data
  output logic int_n_o, // Interrupt, active low
  output logic sync_o, // Real-time pattern sync
  output logic prbs_mode_o, // Pseudorandom mode select
  output logic qrss_mode_o, // QRSS mode select
  output logic tx_invert_select_o, // Transmit data inversion
  output logic [31:0] pattern_set_o, // Pattern set registers
  output logic [7:0] pattern_length_o, // Pattern length register
  output logic [7:0] polynomial_tap_o // Polynomial tap register
);
  // Pin synchronizer: only the second stage is read
  logic [20:0] meta_q, pin_q;
  logic rx_clk_s, rx_data_s, rx_count_disable_s, latch_pin_s, capture_pin_s;
  logic cs_n_s, rd_n_s, wr_n_s;
  logic [4:0] addr_s;
  logic [7:0] data_s;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      meta_q <= bera_pkg::RST_PIN_SYNC;
      pin_q <= bera_pkg::RST_PIN_SYNC;
    end else begin
      meta_q <= {rx_clk_i, rx_data_i, rx_count_disable_i, count_latch_i, rx_capture_i,
                 cs_n_i, rd_n_i, wr_n_i, addr_i, data_i};
      pin_q <= meta_q;
    end
  end

  assign {rx_clk_s, rx_data_s, rx_count_disable_s, latch_pin_s, capture_pin_s,
          cs_n_s, rd_n_s, wr_n_s, addr_s, data_s} = pin_q;

  // Host registers
  logic [31:0] pattern_set, next_pattern_set;
  logic [7:0] pattern_length, next_pattern_length;
  logic [7:0] polynomial_tap, next_polynomial_tap;
  logic [7:0] pattern_control, next_pattern_control;
  logic [7:0] error_insertion, next_error_insertion;
  logic [7:0] interrupt_mask, next_interrupt_mask;
  logic [4:0] wr_addr, next_wr_addr;
  logic [7:0] wr_data, next_wr_data;
  logic wr_pend, next_wr_pend;
  logic rd_sel, next_rd_sel;
  logic [7:0] next_data_o;
  logic [7:0] rd_value;
  logic [6:1] status_clr;
  logic rd_active, wr_active, rd_end, wr_end;

  // Edge detection and analyzer state
  logic rx_clk_prev, rd_n_prev, wr_n_prev, latch_prev, capture_prev, resync_prev;
  logic latch_req, capture_req, resync_req;
  logic rx_rise, latch_evt, capture_evt, resync_evt;
  logic pend_valid, next_pend_valid;
  logic [1:0] pend_data, next_pend_data;
  logic buf_in_ready, buf_out_valid, buf_out_ready;
  logic [1:0] buf_out_data;
  bera_pkg::bera_sync_e sync_state, next_sync_state;
  logic [31:0] ref_pat, next_ref_pat, hist, next_hist, captured, next_captured;
  logic [31:0] bit_cnt, next_bit_cnt, err_cnt, next_err_cnt;
  logic [31:0] bit_cnt_rd, next_bit_cnt_rd, err_cnt_rd, next_err_cnt_rd;
  logic [5:0] match_cnt, next_match_cnt, win_cnt, next_win_cnt;
  logic [5:0] ones_run, next_ones_run, zeros_run, next_zeros_run;
  logic [2:0] win_err, next_win_err;
  logic [6:1] flags, next_flags, flag_set, flag_cond;
  logic [7:0] status;
  logic next_int_n;
  logic [4:0] eff_len, eff_tap;
  logic [32:0] bit_sum, err_sum;
  logic bit_take, rx_bit, rx_count_disable_bit, pred, bit_err;

  function automatic logic [32:0] count_up(input logic [31:0] v);
    count_up = {1'b0, v} + 33'h0_0000_0001;
  endfunction

  function automatic logic [5:0] sat_up(input logic [5:0] v);
    sat_up = (v == bera_pkg::RUN_ALL_BITS) ? v : v + 6'h01;
  endfunction

  // Repetitive: period length+1; pseudorandom: feedback from length and tap
  function automatic logic predict(input logic [31:0] r, input logic [4:0] len,
                                   input logic [4:0] tap, input logic prbs);
    predict = prbs ? (r[len] ^ r[tap]) : r[len];
  endfunction

  assign rd_active = !cs_n_s && !rd_n_s;
  assign wr_active = !cs_n_s && !wr_n_s;
  assign rd_end = rd_n_s && !rd_n_prev;
  assign wr_end = wr_n_s && !wr_n_prev;
  assign data_oe_o = rd_active;
  assign latch_req = pattern_control[bera_pkg::CTRL_LATCH_BIT] | latch_pin_s;
  assign capture_req = pattern_control[bera_pkg::CTRL_CAPTURE_BIT] | capture_pin_s;
  assign resync_req = pattern_control[bera_pkg::CTRL_RESYNC_BIT];
  assign rx_rise = rx_clk_s && !rx_clk_prev;
  assign latch_evt = latch_req && !latch_prev;
  assign capture_evt = capture_req && !capture_prev;
  assign resync_evt = resync_req && !resync_prev;
  assign sync_o = (sync_state == bera_pkg::SYNC_LOCKED);
  assign status = {1'b0, flags, sync_o};
  assign pattern_set_o = pattern_set;
  assign pattern_length_o = pattern_length;
  assign polynomial_tap_o = polynomial_tap;
  assign prbs_mode_o = pattern_control[bera_pkg::CTRL_PRBS_BIT];
  assign qrss_mode_o = pattern_control[bera_pkg::CTRL_QRSS_BIT];
  assign tx_invert_select_o = error_insertion[bera_pkg::EIR_TX_INVERT_BIT];

  always_comb begin
    unique case (addr_s)
      bera_pkg::ADDR_PATTERN_SET3: rd_value = pattern_set[31:24];
      bera_pkg::ADDR_PATTERN_SET2: rd_value = pattern_set[23:16];
      bera_pkg::ADDR_PATTERN_SET1: rd_value = pattern_set[15:8];
      bera_pkg::ADDR_PATTERN_SET0: rd_value = pattern_set[7:0];
      bera_pkg::ADDR_PATTERN_LENGTH: rd_value = pattern_length;
      bera_pkg::ADDR_POLYNOMIAL_TAP: rd_value = polynomial_tap;
      bera_pkg::ADDR_PATTERN_CONTROL: rd_value = pattern_control;
      bera_pkg::ADDR_ERROR_INSERTION: rd_value = error_insertion;
      bera_pkg::ADDR_BIT_COUNT3: rd_value = bit_cnt_rd[31:24];
      bera_pkg::ADDR_BIT_COUNT2: rd_value = bit_cnt_rd[23:16];
      bera_pkg::ADDR_BIT_COUNT1: rd_value = bit_cnt_rd[15:8];
      bera_pkg::ADDR_BIT_COUNT0: rd_value = bit_cnt_rd[7:0];
      bera_pkg::ADDR_ERROR_COUNT3: rd_value = err_cnt_rd[31:24];
      bera_pkg::ADDR_ERROR_COUNT2: rd_value = err_cnt_rd[23:16];
      bera_pkg::ADDR_ERROR_COUNT1: rd_value = err_cnt_rd[15:8];
      bera_pkg::ADDR_ERROR_COUNT0: rd_value = err_cnt_rd[7:0];
      bera_pkg::ADDR_CAPTURED3: rd_value = captured[31:24];
      bera_pkg::ADDR_CAPTURED2: rd_value = captured[23:16];
      bera_pkg::ADDR_CAPTURED1: rd_value = captured[15:8];
      bera_pkg::ADDR_CAPTURED0: rd_value = captured[7:0];
      bera_pkg::ADDR_STATUS: rd_value = status;
      bera_pkg::ADDR_INTERRUPT_MASK: rd_value = interrupt_mask;
      default: rd_value = 8'h00;
    endcase
  end

  // Host port: data and address are held from the strobe, committed at its end
  always_comb begin
    next_pattern_set = pattern_set;
    next_pattern_length = pattern_length;
    next_polynomial_tap = polynomial_tap;
    next_pattern_control = pattern_control;
    next_error_insertion = error_insertion;
    next_interrupt_mask = interrupt_mask;
    next_wr_addr = wr_active ? addr_s : wr_addr;
    next_wr_data = wr_active ? data_s : wr_data;
    next_wr_pend = wr_active || (wr_pend && !wr_end);
    next_rd_sel = rd_active ? (addr_s == bera_pkg::ADDR_STATUS) : (rd_sel && !rd_end);
    next_data_o = rd_active ? rd_value : data_o;
    // Only flags the host actually saw are cleared
    status_clr = (rd_end && rd_sel) ? data_o[6:1] : 6'h00;
    if (wr_end && wr_pend) begin
      unique case (wr_addr)
        bera_pkg::ADDR_PATTERN_SET3: next_pattern_set[31:24] = wr_data;
        bera_pkg::ADDR_PATTERN_SET2: next_pattern_set[23:16] = wr_data;
        bera_pkg::ADDR_PATTERN_SET1: next_pattern_set[15:8] = wr_data;
        bera_pkg::ADDR_PATTERN_SET0: next_pattern_set[7:0] = wr_data;
        bera_pkg::ADDR_PATTERN_LENGTH: next_pattern_length = wr_data;
        bera_pkg::ADDR_POLYNOMIAL_TAP: next_polynomial_tap = wr_data;
        bera_pkg::ADDR_PATTERN_CONTROL: next_pattern_control = wr_data;
        bera_pkg::ADDR_ERROR_INSERTION: next_error_insertion = wr_data;
        bera_pkg::ADDR_INTERRUPT_MASK: next_interrupt_mask = wr_data;
        default: next_wr_pend = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pattern_set <= bera_pkg::RST_PATTERN_SET;
      pattern_length <= bera_pkg::RST_REG8;
      polynomial_tap <= bera_pkg::RST_REG8;
      pattern_control <= bera_pkg::RST_REG8;
      error_insertion <= bera_pkg::RST_REG8;
      interrupt_mask <= bera_pkg::RST_REG8;
      wr_addr <= 5'h00;
      wr_data <= 8'h00;
      wr_pend <= 1'b0;
      rd_sel <= 1'b0;
      data_o <= 8'h00;
    end else begin
      pattern_set <= next_pattern_set;
      pattern_length <= next_pattern_length;
      polynomial_tap <= next_polynomial_tap;
      pattern_control <= next_pattern_control;
      error_insertion <= next_error_insertion;
      interrupt_mask <= next_interrupt_mask;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_pend <= next_wr_pend;
      rd_sel <= next_rd_sel;
      data_o <= next_data_o;
    end
  end

  // Analyzer stalls in a latch cycle so no bit is counted across the copy
  assign buf_out_ready = !latch_evt;

  bera_pair_buffer u_bit_buffer (
    .clk_i(mclk_i),
    .rst_i(sys_rst_i),
    .in_valid_i(pend_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(pend_data),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data)
  );

  always_comb begin
    next_pend_valid = rx_rise || (pend_valid && !buf_in_ready);
    next_pend_data = rx_rise ?
      {rx_count_disable_s, rx_data_s ^ error_insertion[bera_pkg::EIR_RX_INVERT_BIT]} : pend_data;
    bit_take = buf_out_valid && buf_out_ready;
    rx_count_disable_bit = buf_out_data[1];
    rx_bit = buf_out_data[0];
    // QRSS forces its own polynomial
    eff_len = pattern_control[bera_pkg::CTRL_QRSS_BIT] ?
      bera_pkg::QRSS_LENGTH : pattern_length[4:0];
    eff_tap = pattern_control[bera_pkg::CTRL_QRSS_BIT] ?
      bera_pkg::QRSS_TAP : polynomial_tap[4:0];
    pred = predict(ref_pat, eff_len, eff_tap,
                   pattern_control[bera_pkg::CTRL_PRBS_BIT]);
    bit_sum = count_up(bit_cnt);
    err_sum = count_up(err_cnt);
    bit_err = 1'b0;
    flag_set = 6'h00;
    next_sync_state = sync_state;
    next_ref_pat = ref_pat;
    next_hist = hist;
    next_captured = captured;
    next_bit_cnt = bit_cnt;
    next_err_cnt = err_cnt;
    next_bit_cnt_rd = bit_cnt_rd;
    next_err_cnt_rd = err_cnt_rd;
    next_match_cnt = match_cnt;
    next_win_cnt = win_cnt;
    next_win_err = win_err;
    next_ones_run = ones_run;
    next_zeros_run = zeros_run;
    if (latch_evt) begin
      next_bit_cnt_rd = bit_cnt;
      next_err_cnt_rd = err_cnt;
      next_bit_cnt = 32'h0000_0000;
      next_err_cnt = 32'h0000_0000;
    end
    if (bit_take) begin
      next_hist = {hist[30:0], rx_bit};
      next_ones_run = rx_bit ? sat_up(ones_run) : 6'h00;
      next_zeros_run = rx_bit ? 6'h00 : sat_up(zeros_run);
      unique case (sync_state)
        bera_pkg::SYNC_HUNT: begin
          // Self-synchronizing: reference tracks the line until it predicts it
          next_ref_pat = {ref_pat[30:0], rx_bit};
          next_match_cnt = (rx_bit == pred) ? sat_up(match_cnt) : 6'h00;
          if (rx_bit == pred && match_cnt == bera_pkg::SYNC_MATCH_BITS - 6'h01) begin
            next_sync_state = bera_pkg::SYNC_LOCKED;
            next_win_cnt = 6'h00;
            next_win_err = 3'h0;
          end
        end
        bera_pkg::SYNC_LOCKED: begin
          bit_err = (rx_bit != pred);
          next_ref_pat = {ref_pat[30:0], pred};
          flag_set[3] = bit_err;
          if (!rx_count_disable_bit) begin
            next_bit_cnt = bit_sum[31:0];
            flag_set[2] = bit_sum[32];
            if (bit_err) begin
              next_err_cnt = err_sum[31:0];
              flag_set[1] = err_sum[32];
            end
          end
          next_win_cnt = win_cnt + 6'h01;
          if (win_cnt == bera_pkg::WINDOW_LAST) begin
            next_win_err = 3'h0;
          end else if (bit_err && win_err != bera_pkg::WINDOW_ERR_LAST) begin
            next_win_err = win_err + 3'h1;
          end
          if (bit_err && win_err == bera_pkg::WINDOW_ERR_LAST &&
              !pattern_control[bera_pkg::CTRL_RESYNC_OFF_BIT]) begin
            next_sync_state = bera_pkg::SYNC_HUNT;
            next_match_cnt = 6'h00;
          end
        end
      endcase
    end
    if (resync_evt) begin
      next_sync_state = bera_pkg::SYNC_HUNT;
      next_match_cnt = 6'h00;
    end
    if (capture_evt) begin
      next_captured = sync_o ? ref_pat : hist;
    end
    flag_cond = {ones_run == bera_pkg::RUN_ALL_BITS, zeros_run == bera_pkg::RUN_ALL_BITS,
                 !sync_o, 3'h0};
    // Set and standing condition both win over a read clear
    next_flags = flag_cond | flag_set | (flags & ~status_clr);
    next_int_n = ~|(status & interrupt_mask);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rx_clk_prev <= 1'b0;
      rd_n_prev <= 1'b1;
      wr_n_prev <= 1'b1;
      latch_prev <= 1'b0;
      capture_prev <= 1'b0;
      resync_prev <= 1'b0;
      pend_valid <= 1'b0;
      pend_data <= 2'h0;
      sync_state <= bera_pkg::SYNC_HUNT;
      ref_pat <= 32'h0000_0000;
      hist <= 32'h0000_0000;
      captured <= 32'h0000_0000;
      bit_cnt <= 32'h0000_0000;
      err_cnt <= 32'h0000_0000;
      bit_cnt_rd <= 32'h0000_0000;
      err_cnt_rd <= 32'h0000_0000;
      match_cnt <= 6'h00;
      win_cnt <= 6'h00;
      win_err <= 3'h0;
      ones_run <= 6'h00;
      zeros_run <= 6'h00;
      flags <= 6'h00;
      int_n_o <= 1'b1;
    end else begin
      rx_clk_prev <= rx_clk_s;
      rd_n_prev <= rd_n_s;
      wr_n_prev <= wr_n_s;
      latch_prev <= latch_req;
      capture_prev <= capture_req;
      resync_prev <= resync_req;
      pend_valid <= next_pend_valid;
      pend_data <= next_pend_data;
      sync_state <= next_sync_state;
      ref_pat <= next_ref_pat;
      hist <= next_hist;
      captured <= next_captured;
      bit_cnt <= next_bit_cnt;
      err_cnt <= next_err_cnt;
      bit_cnt_rd <= next_bit_cnt_rd;
      err_cnt_rd <= next_err_cnt_rd;
      match_cnt <= next_match_cnt;
      win_cnt <= next_win_cnt;
      win_err <= next_win_err;
      ones_run <= next_ones_run;
      zeros_run <= next_zeros_run;
      flags <= next_flags;
      int_n_o <= next_int_n;
    end
  end
endmodule

// [bera_line_model.sv]
// Serial line source sending a repeating byte, MSB first
`timescale 1ns/1ns
module bera_line_model #(
  parameter logic [7:0] PATTERN = 8'hB4
) (
  output logic rx_clk_o, // Bit clock, still between bursts
  output logic rx_data_o // Serial data
);
  initial {rx_clk_o, rx_data_o} = 2'b00;
  // Every nth bit inverted when every is nonzero
  task automatic send(input int n, input int every);
    for (int i = 0; i < n; i++) begin
      rx_data_o = PATTERN[7 - i % 8] ^ (every > 0 && i % every == every - 1);
      #62 rx_clk_o = 1'b1;
      #63 rx_clk_o = 1'b0;
    end
    rx_data_o = ~rx_data_o;
  endtask
endmodule

// [bera_pair_buffer.sv]
// Small valid/ready FIFO holding received bits between link sampler and analyzer
`timescale 1ns/1ns
module bera_pair_buffer #(
  parameter int WIDTH = bera_pkg::BUF_WIDTH,
  parameter int DEPTH = bera_pkg::BUF_DEPTH
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic in_valid_i, // Source offers a word
  output logic in_ready_o, // Buffer has room
  input wire logic [WIDTH-1:0] in_data_i, // Word offered
  output logic out_valid_o, // Word available
  input wire logic out_ready_i, // Sink takes the word
  output logic [WIDTH-1:0] out_data_o // Oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PW:0] count, next_count;
  logic push, pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST_PTR) ? '0 : p + PW'(1);
  endfunction

  assign in_ready_o = (count != FULL_COUNT);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data_i;
      next_wr_ptr = bump(wr_ptr);
    end
    if (pop) begin
      next_rd_ptr = bump(rd_ptr);
    end
    if (push && !pop) begin
      next_count = count + (PW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (PW+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    mem <= next_mem;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
endmodule

// [bera_pkg.sv]
// Register map, field positions, reset values and counts for the bit error analyzer
package bera_pkg;
  // Host register offsets on the parallel port
  localparam logic [4:0] ADDR_PATTERN_SET3 = 5'h00;
  localparam logic [4:0] ADDR_PATTERN_SET2 = 5'h01;
  localparam logic [4:0] ADDR_PATTERN_SET1 = 5'h02;
  localparam logic [4:0] ADDR_PATTERN_SET0 = 5'h03;
  localparam logic [4:0] ADDR_PATTERN_LENGTH = 5'h04;
  localparam logic [4:0] ADDR_POLYNOMIAL_TAP = 5'h05;
  localparam logic [4:0] ADDR_PATTERN_CONTROL = 5'h06;
  localparam logic [4:0] ADDR_ERROR_INSERTION = 5'h07;
  localparam logic [4:0] ADDR_BIT_COUNT3 = 5'h08;
  localparam logic [4:0] ADDR_BIT_COUNT2 = 5'h09;
  localparam logic [4:0] ADDR_BIT_COUNT1 = 5'h0A;
  localparam logic [4:0] ADDR_BIT_COUNT0 = 5'h0B;
  localparam logic [4:0] ADDR_ERROR_COUNT3 = 5'h0C;
  localparam logic [4:0] ADDR_ERROR_COUNT2 = 5'h0D;
  localparam logic [4:0] ADDR_ERROR_COUNT1 = 5'h0E;
  localparam logic [4:0] ADDR_ERROR_COUNT0 = 5'h0F;
  localparam logic [4:0] ADDR_CAPTURED3 = 5'h10;
  localparam logic [4:0] ADDR_CAPTURED2 = 5'h11;
  localparam logic [4:0] ADDR_CAPTURED1 = 5'h12;
  localparam logic [4:0] ADDR_CAPTURED0 = 5'h13;
  localparam logic [4:0] ADDR_STATUS = 5'h14;
  localparam logic [4:0] ADDR_INTERRUPT_MASK = 5'h15;

  // Pattern control field positions
  localparam int CTRL_QRSS_BIT = 6;
  localparam int CTRL_PRBS_BIT = 5;
  localparam int CTRL_LATCH_BIT = 4;
  localparam int CTRL_CAPTURE_BIT = 3;
  localparam int CTRL_RESYNC_OFF_BIT = 2;
  localparam int CTRL_RESYNC_BIT = 1;

  // Error insertion field positions
  localparam int EIR_TX_INVERT_BIT = 5;
  localparam int EIR_RX_INVERT_BIT = 4;

  // Reset values
  localparam logic [31:0] RST_PATTERN_SET = 32'h0000_0000;
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [20:0] RST_PIN_SYNC = 21'h00E000;

  // QRSS fixed polynomial settings
  localparam logic [4:0] QRSS_TAP = 5'h10;
  localparam logic [4:0] QRSS_LENGTH = 5'h13;

  // Synchronizer counts
  localparam logic [5:0] SYNC_MATCH_BITS = 6'h20;
  localparam logic [5:0] RUN_ALL_BITS = 6'h20;
  localparam logic [5:0] WINDOW_LAST = 6'h3F;
  localparam logic [2:0] WINDOW_ERR_LAST = 3'h5;

  // Receive bit buffer shape
  localparam int BUF_WIDTH = 2;
  localparam int BUF_DEPTH = 2;

  typedef enum logic {
    SYNC_HUNT = 1'b0,
    SYNC_LOCKED = 1'b1
  } bera_sync_e;
endpackage

// [bera_sva.sv]
// Checker on the analyzer's host and configuration ports
`timescale 1ns/1ns
module bera_sva (
  input wire logic mclk_i, sys_rst_i, cs_n_i, wr_n_i, int_n_o, sync_o, // Clock, reset, strobes
  input wire logic prbs_mode_o, qrss_mode_o, tx_invert_select_o, // Mode outputs
  input wire logic [4:0] addr_i, // Register address
  input wire logic [7:0] data_i, data_o, pattern_length_o, polynomial_tap_o, // Bytes
  input wire logic [31:0] pattern_set_o // Pattern set copy
);
  logic wr_low;
  always_ff @(posedge mclk_i) wr_low <= !wr_n_i && !cs_n_i;
  wire logic wr_end = wr_low && wr_n_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Pins pass a two-stage sync, so commit lands a few cycles late
  property p_cfg(ad, ok);
    wr_end && addr_i == ad |-> ##[2:6] ok;
  endproperty
  a_prbs_sel: assert property (
    p_cfg(bera_pkg::ADDR_PATTERN_CONTROL, prbs_mode_o == data_i[5])) else $error("prbs bit");
  a_qrss_sel: assert property (
    p_cfg(bera_pkg::ADDR_PATTERN_CONTROL, qrss_mode_o == data_i[6])) else $error("qrss bit");
  a_tap_copy: assert property (
    p_cfg(bera_pkg::ADDR_POLYNOMIAL_TAP, polynomial_tap_o == data_i)) else $error("tap");
  a_tx_invert: assert property (
    p_cfg(bera_pkg::ADDR_ERROR_INSERTION, tx_invert_select_o == data_i[5])) else $error("tx_invert_select");
  a_len_copy: assert property (
    p_cfg(bera_pkg::ADDR_PATTERN_LENGTH, pattern_length_o == data_i)) else $error("length");
  a_set_low: assert property (
    p_cfg(bera_pkg::ADDR_PATTERN_SET0, pattern_set_o[7:0] == data_i)) else $error("set0");
  a_mask_quiet: assert property (
    wr_end && addr_i == bera_pkg::ADDR_INTERRUPT_MASK && data_i == 8'h00 |-> ##[3:8] int_n_o)
    else $error("masked interrupt");
  a_read_hold: assert property (cs_n_i[*6] |-> $stable(data_o)) else $error("data moved");
  c_sync: cover property ($rose(sync_o));
  c_int: cover property ($fell(int_n_o));
  c_ctrl: cover property (wr_end && addr_i == bera_pkg::ADDR_PATTERN_CONTROL);
endmodule
bind bera_analyzer bera_sva chk (.*);

// [tb_bera_analyzer.sv]
// Self-checking bench for the bit error analyzer
`timescale 1ns/1ns
module tb_bera_analyzer;
  logic mclk_i = 0, sys_rst_i = 1, lc = 0, rx_count_disable = 0, cs_n = 1, rd_n = 1, wr_n = 1, rck, rdt;
  logic [4:0] a = 0;
  logic [7:0] d = 0, data_o;
  logic data_oe_o, int_n_o, sync_o;
  int failures = 0, checked = 0;
  always #2 mclk_i = ~mclk_i;
  bera_line_model line (.rx_clk_o(rck), .rx_data_o(rdt));
  bera_analyzer dut (.mclk_i, .sys_rst_i, .rx_clk_i(rck), .rx_data_i(rdt),
    .rx_count_disable_i(rx_count_disable), .count_latch_i(lc), .rx_capture_i(1'b0), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(a), .data_i(d), .data_o, .data_oe_o, .int_n_o,
    .sync_o, .prbs_mode_o(), .qrss_mode_o(), .tx_invert_select_o(), .pattern_set_o(),
    .pattern_length_o(), .polynomial_tap_o());
  task automatic cmp(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] ad, input logic [7:0] v);
    @(negedge mclk_i) {cs_n, wr_n, a, d} = {2'b00, ad, v};
    repeat (5) @(negedge mclk_i);
    {cs_n, wr_n} = 2'b11;
    repeat (5) @(negedge mclk_i);
  endtask
  task automatic rd(input logic [4:0] ad, input logic [7:0] e);
    @(negedge mclk_i) {cs_n, rd_n, a} = {2'b00, ad};
    repeat (6) @(negedge mclk_i);
    cmp(data_o, e);
    {cs_n, rd_n} = 2'b11;
    repeat (5) @(negedge mclk_i);
  endtask
  task automatic rd32(input logic [4:0] ad, input logic [31:0] e);
    for (int i = 0; i < 4; i++) begin
      rd(5'(ad + i), e[31 - 8 * i -: 8]);
    end
  endtask
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #40000;
    failures++;
    conclude();
  end
  initial begin
    repeat (4) @(negedge mclk_i);
    sys_rst_i = 0;
    rd(bera_pkg::ADDR_PATTERN_LENGTH, 8'h00);
    wr(bera_pkg::ADDR_PATTERN_LENGTH, 8'h07);
    rd(bera_pkg::ADDR_PATTERN_LENGTH, 8'h07);
    wr(bera_pkg::ADDR_PATTERN_SET0, 8'hB4);
    wr(bera_pkg::ADDR_POLYNOMIAL_TAP, 8'h10);
    wr(bera_pkg::ADDR_BIT_COUNT0, 8'h5A);
    rd(bera_pkg::ADDR_BIT_COUNT0, 8'h00);
    rd(5'h1F, 8'h00);
    wr(bera_pkg::ADDR_INTERRUPT_MASK, 8'h08);
    line.send(32, 0);
    wr(bera_pkg::ADDR_PATTERN_CONTROL, 8'h08);
    rd32(bera_pkg::ADDR_CAPTURED3, 32'hB4B4B4B4);
    wr(bera_pkg::ADDR_PATTERN_CONTROL, 8'h10);
    rd(bera_pkg::ADDR_BIT_COUNT0, 8'h00);
    line.send(64, 0);
    rd(bera_pkg::ADDR_STATUS, 8'h11);
    rd(bera_pkg::ADDR_STATUS, 8'h01);
    wr(bera_pkg::ADDR_PATTERN_CONTROL, 8'h00);
    wr(bera_pkg::ADDR_PATTERN_CONTROL, 8'h10);
    wr(bera_pkg::ADDR_PATTERN_CONTROL, 8'h00);
    cmp({7'h0, int_n_o}, 8'h01);
    line.send(40, 13);
    cmp({7'h0, int_n_o}, 8'h00);
    @(negedge mclk_i) lc = 1;
    repeat (8) @(negedge mclk_i);
    lc = 0;
    rd32(bera_pkg::ADDR_BIT_COUNT3, 32'd40);
    rd32(bera_pkg::ADDR_ERROR_COUNT3, 32'd3);
    rd(bera_pkg::ADDR_STATUS, 8'h09);
    rd(bera_pkg::ADDR_STATUS, 8'h01);
    cmp({7'h0, int_n_o}, 8'h01);
    // Bits sent with count-disable high must leave the bit count at zero
    @(negedge mclk_i) rx_count_disable = 1;
    line.send(8, 0);
    repeat (8) @(negedge mclk_i);
    rx_count_disable = 0;
    wr(bera_pkg::ADDR_PATTERN_CONTROL, 8'h10);
    rd32(bera_pkg::ADDR_BIT_COUNT3, 32'd0);
    wr(bera_pkg::ADDR_ERROR_INSERTION, 8'h20);
    wr(bera_pkg::ADDR_INTERRUPT_MASK, 8'h00);
    conclude();
  end
endmodule
